// >>> hdl/low_power_mode_controller.sv
`timescale 1ns/1ps
module low_power_mode_controller
    import lpm_pkg::*;
(
    input  wire logic       clk,          // system clock
    input  wire logic       rst,          // async reset, active high
    input  wire lp_req_t    lp_req,       // entry request pulse from the core
    input  wire clk_src_t   src_sel,      // clock source software selected
    input  wire logic       any_event,    // any interrupt or event (sleep wake)
    input  wire deep_wake_t deep_wake,    // deep-sleep wake sources
    input  wire stby_wake_t stby_wake,    // standby wake sources
    output pwr_state_t      state,        // current power state
    output pwr_ctl_t        pwr_ctl,      // clock and power enables
    output clk_src_t        sys_src,      // active system clock source
    output logic            por_rst       // power-on reset to the core domain
);

    ////////////////////////////////////////////////////////////////////////////
    pwr_state_t state_r, state_nxt;
    clk_src_t   src_r, src_nxt;
    clk_src_t   sel_seen_r, sel_seen_nxt;
    pwr_ctl_t   ctl_r, ctl_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic       por_r, por_nxt;

    // enables per state; a function so state and output stay consistent
    function automatic pwr_ctl_t ctl_of(input pwr_state_t s);
        pwr_ctl_t c;
        c = CTL_RUN;
        case (s)
            ST_SLEEP: begin
                c.core_clk_en = 1'b0;
            end
            ST_DEEP: begin
                c.core_clk_en     = 1'b0;
                c.periph_clk_en   = 1'b0;
                c.core_dom_clk_en = 1'b0;
                c.lp_irc_en       = 1'b0;
                c.fast_irc_en     = 1'b0;
                c.crystal_en      = 1'b0;
                c.pll_en          = 1'b0;
                c.retain          = 1'b1;
            end
            ST_STANDBY, ST_POR: begin
                c             = '0;
                c.retain      = 1'b0;
            end
            default: c = CTL_RUN;
        endcase
        return c;
    endfunction : ctl_of

    ////////////////////////////////////////////////////////////////////////////
    // next state; RUN checks only requests and each low-power state only its own wake, so a wake that arrives in RUN is dropped
    always_comb begin
        state_nxt = state_r;
        src_nxt      = src_r;
        sel_seen_nxt = src_sel;
        cnt_nxt      = cnt_r;
        por_nxt      = 1'b0;
        case (state_r)
            ST_RUN: begin
                // only a new selection moves the source, so the forced switch to
                // the fast oscillator holds until software selects again; a change
                // made while the core clock is off is not seen
                if (src_sel != sel_seen_r) begin
                    src_nxt = src_sel;
                end
                case (lp_req)
                    REQ_SLEEP:   state_nxt = ST_SLEEP;
                    REQ_DEEP:    state_nxt = ST_DEEP;
                    REQ_STANDBY: state_nxt = ST_STANDBY;
                    default:     state_nxt = ST_RUN;
                endcase
            end
            ST_SLEEP: begin
                if (any_event) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_DEEP: begin
                if (|deep_wake) begin
                    state_nxt = ST_RUN;
                    src_nxt   = SRC_FAST_IRC;
                end
            end
            ST_STANDBY: begin
                if (|stby_wake) begin
                    state_nxt = ST_POR;
                    cnt_nxt   = '0;
                    por_nxt   = 1'b1;
                end
            end
            ST_POR: begin
                // hold reset a fixed time; core restarts from reset vector
                por_nxt = (cnt_r != POR_CNT_MAX);
                cnt_nxt = cnt_r + 8'h01;
                if (cnt_r == POR_CNT_MAX) begin
                    state_nxt = ST_RUN;
                    src_nxt   = SRC_RST;
                end
            end
            default: state_nxt = ST_RUN;
        endcase
        ctl_nxt = ctl_of(state_nxt);
    end

    // registers only; outputs come straight from these flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= STATE_RST;
            src_r   <= SRC_RST;
            sel_seen_r <= SRC_RST;
            ctl_r   <= CTL_RUN;
            cnt_r   <= 8'h00;
            por_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            src_r   <= src_nxt;
            sel_seen_r <= sel_seen_nxt;
            ctl_r   <= ctl_nxt;
            cnt_r   <= cnt_nxt;
            por_r   <= por_nxt;
        end
    end

    assign state   = state_r;
    assign pwr_ctl = ctl_r;
    assign sys_src = src_r;
    assign por_rst = por_r;

    ////////////////////////////////////////////////////////////////////////////
    // checker helper: counts cycles of restart reset independently of cnt_r
    logic [7:0] por_seen_r, por_seen_nxt;

    always_comb begin
        por_seen_nxt = por_r ? por_seen_r + 8'h01 : 8'h00;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            por_seen_r <= 8'h00;
        end else begin
            por_seen_r <= por_seen_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    sequence s_in_sleep;
        state_r == ST_SLEEP;
    endsequence
    sequence s_deep_wake;
        state_r == ST_DEEP && (|deep_wake);
    endsequence

    property p_sleep_clk;
        @(posedge clk) disable iff (rst)
        s_in_sleep |-> !ctl_r.core_clk_en && ctl_r.periph_clk_en;
    endproperty
    a_sleep_clk: assert property (p_sleep_clk) else $error("sleep clock gating wrong");

    property p_sleep_wake;
        @(posedge clk) disable iff (rst)
        s_in_sleep ##0 any_event |=> state_r == ST_RUN && ctl_r.core_clk_en;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) else $error("sleep did not wake");

    property p_deep_off;
        @(posedge clk) disable iff (rst)
        state_r == ST_DEEP |-> !(ctl_r.core_dom_clk_en || ctl_r.lp_irc_en
            || ctl_r.fast_irc_en || ctl_r.crystal_en || ctl_r.pll_en);
    endproperty
    a_deep_off: assert property (p_deep_off) else $error("deep-sleep clock left on");

    property p_deep_retain;
        @(posedge clk) disable iff (rst)
        state_r == ST_DEEP |-> ctl_r.retain && ctl_r.core_pwr_en;
    endproperty
    a_deep_retain: assert property (p_deep_retain) else $error("deep-sleep lost retention");

    property p_deep_wake;
        @(posedge clk) disable iff (rst)
        s_deep_wake |=> state_r == ST_RUN;
    endproperty
    a_deep_wake: assert property (p_deep_wake) else $error("deep-sleep did not wake");

    property p_deep_src;
        @(posedge clk) disable iff (rst)
        s_deep_wake |=> sys_src == SRC_FAST_IRC;
    endproperty
    a_deep_src: assert property (p_deep_src) else $error("wrong clock after deep-sleep");

    // the forced source must not fall back to the old selection by itself
    property p_src_hold;
        @(posedge clk) disable iff (rst)
        s_deep_wake ##1 (src_sel == sel_seen_r) |=> sys_src == SRC_FAST_IRC;
    endproperty
    a_src_hold: assert property (p_src_hold) else $error("clock source not held");

    property p_stby_off;
        @(posedge clk) disable iff (rst)
        state_r == ST_STANDBY |-> ctl_r == '0;
    endproperty
    a_stby_off: assert property (p_stby_off) else $error("standby left power on");

    property p_stby_only;
        @(posedge clk) disable iff (rst)
        state_r == ST_STANDBY && !(|stby_wake) |=> state_r == ST_STANDBY;
    endproperty
    a_stby_only: assert property (p_stby_only) else $error("standby woke without source");

    property p_stby_por;
        @(posedge clk) disable iff (rst)
        state_r == ST_STANDBY && (|stby_wake) |=> por_r && !ctl_r.retain
            ##1 state_r == ST_POR;
    endproperty
    a_stby_por: assert property (p_stby_por) else $error("standby wake skipped reset");

    property p_por_len;
        @(posedge clk) disable iff (rst)
        $rose(por_r) |-> por_r[*8] ##[1:30] (state_r == ST_RUN && !por_r);
    endproperty
    a_por_len: assert property (p_por_len) else $error("power-on restart length wrong");

    property p_por_exact;
        @(posedge clk) disable iff (rst)
        $fell(por_r) |-> por_seen_r == POR_CNT_MAX + 8'h01 && state_r == ST_RUN;
    endproperty
    a_por_exact: assert property (p_por_exact) else $error("restart hold length wrong");

endmodule : low_power_mode_controller

// >>> common/lpm_pkg.sv
package lpm_pkg;

    // power state encoding
    typedef enum logic [2:0] {
        ST_RUN        = 3'h0,
        ST_SLEEP      = 3'h1,
        ST_DEEP       = 3'h2,
        ST_STANDBY    = 3'h3,
        ST_POR        = 3'h4
    } pwr_state_t;

    // entry request from the core
    typedef enum logic [1:0] {
        REQ_NONE      = 2'h0,
        REQ_SLEEP     = 2'h1,
        REQ_DEEP      = 2'h2,
        REQ_STANDBY   = 2'h3
    } lp_req_t;

    // system clock source select
    typedef enum logic [1:0] {
        SRC_FAST_IRC  = 2'h0,
        SRC_CRYSTAL   = 2'h1,
        SRC_PLL       = 2'h2,
        SRC_LP_IRC    = 2'h3
    } clk_src_t;

    // deep-sleep wake sources of the external interrupt controller
    typedef struct packed {
        logic [15:0] ext_line;
        logic        cal_alarm;
        logic        tamper_tstamp;
        logic        slow_xtal_stuck;
        logic        volt_det;
        logic        cmp_out;
        logic        temp_wake;
        logic        cal_wake;
        logic        can_wake;
        logic        i2c_wake;
        logic        usart_wake;
        logic        usb_wake;
    } deep_wake_t;

    // standby wake sources
    typedef struct packed {
        logic ext_reset_pin;
        logic calendar;
        logic watchdog_rst;
        logic wake_pin;
        logic lockup_mon;
    } stby_wake_t;

    // clock and power enables driven out
    typedef struct packed {
        logic core_clk_en;
        logic periph_clk_en;
        logic core_dom_clk_en;
        logic lp_irc_en;
        logic fast_irc_en;
        logic crystal_en;
        logic pll_en;
        logic regulator_en;
        logic core_pwr_en;
        logic retain;
    } pwr_ctl_t;

    localparam pwr_state_t STATE_RST   = ST_RUN;
    localparam clk_src_t   SRC_RST     = SRC_FAST_IRC;
    localparam pwr_ctl_t   CTL_RUN     = 10'h3FF;
    // power-on restart hold after standby wake
    localparam int         POR_NS      = 100;
    localparam int         CLK_NS      = 5;
    localparam int         POR_CYC     = (POR_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] POR_CNT_MAX = 8'(POR_CYC - 1);

endpackage : lpm_pkg

// >>> verification/wake_source_model.sv
`timescale 1ns/1ps
module wake_source_model
    import lpm_pkg::*;
(
    input  wire logic       clk,       // system clock
    input  wire logic       rst,       // async reset, active high
    input  wire logic       fire,      // raise one source in the next cycle
    input  wire logic [1:0] kind,      // 1 event, 2 deep-sleep, 3 standby
    input  wire logic [4:0] idx,       // bit of the chosen source group
    output logic            any_event, // sleep wake
    output deep_wake_t      deep_wake, // deep-sleep sources
    output stby_wake_t      stby_wake  // standby sources
);
    // one-cycle pulses: a level left high would hide a wake taken late
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            any_event <= 1'b0;
            deep_wake <= '0;
            stby_wake <= '0;
        end else begin
            any_event <= fire && kind == 2'h1;
            deep_wake <= (fire && kind == 2'h2) ? 27'h1 << idx : '0;
            stby_wake <= (fire && kind == 2'h3) ? 5'h1 << idx : '0;
        end
    end
endmodule : wake_source_model

// >>> verification/low_power_mode_controller_tb_top.sv
`timescale 1ns/1ps
module low_power_mode_controller_tb_top;
    import lpm_pkg::*;
    logic       clk, rst, fire, any_event, por_rst;
    logic [1:0] kind;
    logic [4:0] idx;
    lp_req_t    lp_req;
    clk_src_t   src_sel, sys_src;
    deep_wake_t deep_wake;
    stby_wake_t stby_wake;
    pwr_state_t state;
    pwr_ctl_t   pwr_ctl;
    int         failures, checks;

    ////////////////////////////////////////////////////////////////////////
    low_power_mode_controller dut (.clk(clk), .rst(rst), .lp_req(lp_req),
        .src_sel(src_sel), .any_event(any_event), .deep_wake(deep_wake),
        .stby_wake(stby_wake), .state(state), .pwr_ctl(pwr_ctl),
        .sys_src(sys_src), .por_rst(por_rst));
    wake_source_model wsm (.clk(clk), .rst(rst), .fire(fire), .kind(kind),
        .idx(idx), .any_event(any_event), .deep_wake(deep_wake),
        .stby_wake(stby_wake));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // request is taken one edge after it is driven; look after that edge
    task automatic req(input lp_req_t r);
        @(posedge clk);
        lp_req <= r;
        @(posedge clk);
        lp_req <= REQ_NONE;
        #1;
    endtask : req

    // source pulses one cycle after fire, design answers at the next edge
    task automatic wake(input logic [1:0] k, input int i);
        @(posedge clk);
        fire <= 1'b1;
        kind <= k;
        idx  <= 5'(i);
        @(posedge clk);
        fire <= 1'b0;
        @(posedge clk);
        #1;
    endtask : wake

    task automatic tally_and_finish();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : tally_and_finish

    ////////////////////////////////////////////////////////////////////////
    task automatic test_sleep();
        req(REQ_SLEEP);
        check("sleep ctl", 10'(pwr_ctl), 10'h1FF);
        wake(2'h2, 0);
        check("sleep deep ign", 10'(state), 10'(ST_SLEEP));
        wake(2'h3, 0);
        check("sleep stby ign", 10'(state), 10'(ST_SLEEP));
        wake(2'h1, 0);
        check("sleep wake", 10'(state), 10'(ST_RUN));
        check("sleep wake ctl", 10'(pwr_ctl), 10'h3FF);
    endtask : test_sleep

    // every source bit, with a non-default clock chosen before entry
    task automatic test_deep();
        @(posedge clk);
        src_sel <= SRC_PLL;
        for (int i = 0; i < 27; i++) begin
            req(REQ_DEEP);
            check("deep ctl", 10'(pwr_ctl), 10'h007);
            // first entry runs on the chosen source, later ones keep the forced one
            check("deep src in", 10'(sys_src), (i == 0) ? 10'(SRC_PLL) : 10'(SRC_FAST_IRC));
            if (i == 0) begin
                wake(2'h1, 0);
                check("deep evt ign", 10'(state), 10'(ST_DEEP));
            end
            wake(2'h2, i);
            check("deep wake", 10'(state), 10'(ST_RUN));
            check("deep src", 10'(sys_src), 10'(SRC_FAST_IRC));
        end
    endtask : test_deep

    task automatic test_standby();
        for (int i = 0; i < 5; i++) begin
            req(REQ_STANDBY);
            check("stby ctl", 10'(pwr_ctl), 10'h000);
            if (i == 0) begin
                wake(2'h2, 0);
                check("stby deep ign", 10'(state), 10'(ST_STANDBY));
            end
            wake(2'h3, i);
            check("stby wake", 10'(state), 10'(ST_POR));
            check("stby por", 10'(por_rst), 10'h001);
            repeat (POR_CYC - 1) @(posedge clk);
            #1;
            check("por hold", 10'(por_rst), 10'h001);
            check("por hold st", 10'(state), 10'(ST_POR));
            @(posedge clk);
            #1;
            check("por end", 10'(state), 10'(ST_RUN));
            check("por rel", 10'(por_rst), 10'h000);
            check("por ctl", 10'(pwr_ctl), 10'h3FF);
            check("por src", 10'(sys_src), 10'(SRC_FAST_IRC));
        end
    endtask : test_standby

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // whole run is a few hundred cycles; this bound only catches a hang
    initial begin
        #50000;
        failures++;
        tally_and_finish();
    end

    initial begin
        {rst, fire, kind, idx, failures, checks} = {1'b1, 8'h00, 64'h0};
        lp_req  = REQ_NONE;
        src_sel = SRC_CRYSTAL;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        #1;
        check("rst state", 10'(state), 10'(STATE_RST));
        check("rst ctl", 10'(pwr_ctl), 10'(CTL_RUN));
        check("rst por", 10'(por_rst), 10'h000);
        check("rst src", 10'(sys_src), 10'(SRC_RST));
        test_sleep();
        test_deep();
        test_standby();
        tally_and_finish();
    end
endmodule : low_power_mode_controller_tb_top
